// ### bench/cmf_can_model.sv
// CAN engine stand-in: capture points and completion pulses.
// Assumes the bench calls frame(); pulses last one pclk cycle.
`timescale 1ns/1ps
`default_nettype none
module cmf_can_model (
  // Clock
  input wire pclk,
  // Engine events
  output logic rx_msg_done,
  output logic tx_done,
  output logic [28:0] tx_id,
  output logic frame_is_fd,
  output logic sof_sample,
  output logic res_bit_sample,
  output logic rx_eof_point,
  output logic tx_eof_point
);
  initial begin
    {rx_msg_done, tx_done, frame_is_fd, sof_sample, res_bit_sample} = 5'h00;
    {rx_eof_point, tx_eof_point} = 2'h0;
    tx_id = 29'h1555_5555;
  end
  // Start capture first, end capture later, then completion
  task automatic frame(input logic tx, input logic [28:0] id);
    @(posedge pclk) sof_sample <= 1'b1;
    @(posedge pclk) sof_sample <= 1'b0;
    rx_eof_point <= !tx;
    tx_eof_point <= tx;
    @(posedge pclk) {rx_eof_point, tx_eof_point} <= 2'h0;
    rx_msg_done <= !tx;
    tx_done <= tx;
    tx_id <= id;
    // Id no longer valid after the pulse, so show its inverse
    @(posedge pclk) {rx_msg_done, tx_done} <= 2'h0;
    tx_id <= ~id;
    repeat (2) @(posedge pclk);
  endtask
endmodule // cmf_can_model
`default_nettype wire

// ### bench/cmf_fifo_asserts.sv
// Checker for the FIFO pointer block: APB timing and store causes.
// Assumes binding to cmf_fifo_ptr; sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module cmf_fifo_asserts #(parameter EV_DEPTH = 12) (
  // Clock, reset and APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  // Events and stores
  input wire rx_msg_done,
  input wire tx_done,
  input wire [28:0] tx_id,
  input wire rx_store_we,
  input wire ev_store_we,
  input wire [3:0] ev_store_obj,
  input wire [28:0] ev_store_id,
  input wire [2:0] queue_next_index
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire wr;
  assign wr = psel && penable && pwrite;
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  chk_zero_wait: assert property (s_setup ##1 s_access |-> pready && !pslverr)
    else $error("access not answered at once");
  chk_ready_place: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("pready held too long");
  chk_rdata_hold: assert property (!psel |=> $stable(prdata))
    else $error("read data moved while idle");
  chk_rx_cause: assert property (rx_store_we |-> $past(rx_msg_done) || $past(rx_msg_done, 2))
    else $error("receive store without message");
  chk_ev_cause: assert property (ev_store_we |->
    ($past(tx_done) && ev_store_id == $past(tx_id)) ||
    ($past(tx_done, 2) && ev_store_id == $past(tx_id, 2)))
    else $error("event store id mismatch");
  chk_ev_range: assert property (ev_store_we |-> ev_store_obj < EV_DEPTH)
    else $error("event object out of range");
  chk_qidx_cause: assert property ($changed(queue_next_index) |->
    $past(tx_done) || $past(tx_done, 2) || $past(wr) || $past(wr, 2))
    else $error("queue index moved without cause");
endmodule // cmf_fifo_asserts
bind cmf_fifo_ptr cmf_fifo_asserts #(.EV_DEPTH(EV_DEPTH)) cmf_fifo_asserts_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .rx_msg_done(rx_msg_done),
  .tx_done(tx_done), .tx_id(tx_id), .rx_store_we(rx_store_we), .ev_store_we(ev_store_we),
  .ev_store_obj(ev_store_obj), .ev_store_id(ev_store_id),
  .queue_next_index(queue_next_index));
`default_nettype wire

// ### bench/tb.sv
// Bench for the FIFO pointer block over APB.
// Assumes the design answers APB with zero wait states.
`timescale 1ns/1ps
`default_nettype none
`include "cmf_consts.vh"
module tb;
  logic pclk = 0;
  logic presetn = 0;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [28:0] q_load_id = 0;
  logic [31:0] q, e;
  logic [28:0] ids [3] = '{29'd30, 29'd10, 29'd20};
  integer err_count = 0;
  integer checks_done = 0;
  integer i, n;
  wire [31:0] prdata;
  wire pready, pslverr, rx_msg_done, tx_done, frame_is_fd, sof_sample, res_bit_sample;
  wire rx_eof_point, tx_eof_point, queue_tx_valid, rollover_irq;
  wire [28:0] tx_id;
  wire [2:0] queue_next_index;
  wire [31:0] stamp_word;
  always #25 pclk = ~pclk;
  cmf_can_model cmf_can_model_inst (.pclk(pclk), .rx_msg_done(rx_msg_done),
    .tx_done(tx_done), .tx_id(tx_id), .frame_is_fd(frame_is_fd), .sof_sample(sof_sample),
    .res_bit_sample(res_bit_sample), .rx_eof_point(rx_eof_point),
    .tx_eof_point(tx_eof_point));
  cmf_fifo_ptr cmf_fifo_ptr_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .rx_msg_done(rx_msg_done), .tx_done(tx_done),
    .tx_id(tx_id), .frame_is_fd(frame_is_fd), .sof_sample(sof_sample),
    .res_bit_sample(res_bit_sample), .rx_eof_point(rx_eof_point),
    .tx_eof_point(tx_eof_point), .q_load_id(q_load_id), .rx_store_we(), .rx_store_obj(),
    .ev_store_we(), .ev_store_obj(), .ev_store_id(), .stamp_word(stamp_word), .stamp_valid(),
    .queue_tx_valid(queue_tx_valid), .queue_next_index(queue_next_index),
    .rollover_irq(rollover_irq));
  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer k;
    @(posedge pclk) {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk) penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    q = prdata;
    {psel, penable} <= 2'b00;
    if (k == 16) begin
      chk("pready", 1, 0);
      final_report();
    end
  endtask
  task automatic rchk(input string nm, input logic [11:0] a, input logic [31:0] x,
      input logic [31:0] m);
    apb(1'b0, a, 0);
    chk(nm, x, q & m);
  endtask
  // Occupancy flags: not empty, at least half, full
  function automatic logic [31:0] st(input integer c, input integer dep);
    st = 32'(c > 0) | 32'(2 * (2 * c >= dep)) | 32'(4 * (c == dep));
  endfunction
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk("rxsta", `CMF_OFF_RXSTA, 0, 32'hffffffff);
    rchk("qsta", `CMF_OFF_QSTA, 32'h3, 32'h7f);
    rchk("evsta", `CMF_OFF_EVSTA, 0, 32'hffffffff);
    rchk("unmapped", 12'h020, 0, 32'hffffffff);
    for (i = 1; i <= 17; i++) begin
      cmf_can_model_inst.frame(1'b0, 29'h0);
      n = (i > 16) ? 16 : i;
      e = st(n, 16) | 32'(8 * (i > 16)) | 32'((n % 16) << 13);
      rchk("rxsta", `CMF_OFF_RXSTA, e, 32'h1ffff);
    end
    apb(1'b1, `CMF_OFF_CMD, 32'h81);
    apb(1'b1, `CMF_OFF_CMD, 32'h1);
    rchk("rxsta", `CMF_OFF_RXSTA, 32'h403, 32'h1ffff);
    apb(1'b1, `CMF_OFF_CMD, 32'h8);
    rchk("rxsta", `CMF_OFF_RXSTA, 0, 32'h1ffff);
    for (i = 0; i < 3; i++) begin
      q_load_id <= ids[i];
      apb(1'b1, `CMF_OFF_CMD, 32'h2);
    end
    rchk("qsta", `CMF_OFF_QSTA, 32'h32, 32'h7f);
    apb(1'b1, `CMF_OFF_CMD, 32'h40);
    rchk("qsta", `CMF_OFF_QSTA, 32'hba, 32'h3ff);
    chk("qvalid", 1, queue_tx_valid);
    cmf_can_model_inst.frame(1'b1, 29'd10);
    rchk("qsta", `CMF_OFF_QSTA, 32'h13a, 32'h3ff);
    cmf_can_model_inst.frame(1'b1, 29'd20);
    cmf_can_model_inst.frame(1'b1, 29'd30);
    rchk("qsta", `CMF_OFF_QSTA, 32'h33, 32'h7f);
    chk("qvalid", 0, queue_tx_valid);
    q_load_id <= 29'd5;
    apb(1'b1, `CMF_OFF_CMD, 32'h2);
    rchk("qsta", `CMF_OFF_QSTA, 32'h2, 32'h7f);
    apb(1'b1, `CMF_OFF_CMD, 32'h30);
    rchk("qsta", `CMF_OFF_QSTA, 32'h3, 32'h7f);
    rchk("evsta", `CMF_OFF_EVSTA, 0, 32'hffff);
    for (i = 1; i <= 13; i++) begin
      cmf_can_model_inst.frame(1'b1, 29'(i));
      n = (i > 12) ? 12 : i;
      e = st(n, 12) | 32'(8 * (i > 12)) | 32'((n % 12) << 12);
      rchk("evsta", `CMF_OFF_EVSTA, e, 32'hffff);
    end
    apb(1'b1, `CMF_OFF_CMD, 32'h104);
    rchk("evsta", `CMF_OFF_EVSTA, 32'h103, 32'hffff);
    apb(1'b1, `CMF_OFF_PRESC, 32'h3);
    apb(1'b1, `CMF_OFF_TBC, 32'hfffffff0);
    rchk("tbc", `CMF_OFF_TBC, 32'hfffffff0, 32'hffffffff);
    apb(1'b1, `CMF_OFF_CTRL, 32'h9);
    // Sixteen ticks of four cycles reach the wrap
    repeat (100) @(posedge pclk);
    chk("rollover", 1, rollover_irq);
    apb(1'b1, `CMF_OFF_CTRL, 32'h8);
    apb(1'b1, `CMF_OFF_CMD, 32'h200);
    rchk("tbc", `CMF_OFF_TBC, 0, 32'hffffffff);
    chk("rollover", 0, rollover_irq);
    apb(1'b1, `CMF_OFF_TBC, 32'h00001234);
    apb(1'b1, `CMF_OFF_CTRL, 32'h00000004);
    cmf_can_model_inst.frame(1'b0, 29'h0);
    chk("stamp_word", 32'h00001234, stamp_word);
    rchk("stamp", `CMF_OFF_STAMP, 32'h00001234, 32'hffffffff);
    // Stamp enable off: capture still runs, delivery must not
    apb(1'b1, `CMF_OFF_TBC, 32'h00005678);
    apb(1'b1, `CMF_OFF_CTRL, 32'h00000000);
    cmf_can_model_inst.frame(1'b0, 29'h0);
    chk("stamp_word", 32'h00001234, stamp_word);
    rchk("stamp", `CMF_OFF_STAMP, 32'h00005678, 32'hffffffff);
    final_report();
  end
endmodule // tb
`default_nettype wire

// ### shared/cmf_consts.vh
// Constants for the message FIFO pointer and time base block.
// Assumes 32-bit APB data, word-aligned registers.
`ifndef CMF_CONSTS_VH
`define CMF_CONSTS_VH
`define CMF_OFF_CTRL 12'h000
`define CMF_OFF_PRESC 12'h004
`define CMF_OFF_TBC 12'h008
`define CMF_OFF_RXSTA 12'h00c
`define CMF_OFF_QSTA 12'h010
`define CMF_OFF_EVSTA 12'h014
`define CMF_OFF_CMD 12'h018
`define CMF_OFF_STAMP 12'h01c
// Control register bits
`define CMF_CTRL_TBEN 0
`define CMF_CTRL_EVTS 1
`define CMF_CTRL_RXTS 2
`define CMF_CTRL_ROLLIE 3
`define CMF_CTRL_EOF 4
`define CMF_CTRL_RES 5
// Command register bits, write one to act
`define CMF_CMD_RX_INC 0
`define CMF_CMD_Q_INC 1
`define CMF_CMD_EV_INC 2
`define CMF_CMD_RX_RST 3
`define CMF_CMD_Q_RST 4
`define CMF_CMD_EV_RST 5
`define CMF_CMD_TRANSMIT_REQUEST 6
`define CMF_CMD_RXOV_CLR 7
`define CMF_CMD_EVOV_CLR 8
`define CMF_CMD_ROLL_CLR 9
// Object counts
`define CMF_RX_DEPTH 16
`define CMF_Q_DEPTH 8
`define CMF_EV_DEPTH 12
`endif

// ### src/cmf_fifo_ptr.v
// Pointer and status logic for one RX FIFO, the priority queue and the event log.
// Assumes CAN-side strobes are one-cycle pulses from logic on pclk.
// Summary of operation
// - RX reset clears flags, points read address and store index at object 0.
// - Received message into non-full FIFO stored, index advances, not-empty set.
// - Host increment advances read address only, flags follow.
// - Half flag at half occupancy; all three flags when full.
// - Message into full FIFO discarded, overrun set, pointers hold.
// - Host clears overrun; release from full clears full flag.
// - Queue next index recomputed on transmit or transmit request.
// - Queue reset sets empty and not-full flags, load address to object 0.
// - Queue increment advances head and clears empty flag.
// - Transmit of the last pending object clears request; empty set once no object is used; load address holds.
// - Load address points to a free object, not necessarily sequential.
// - Full queue clears flags; transmission by identifier priority.
// - Event log reset clears flags, read address to object 0.
// - Each transmit into a non-full log stores identifier into next event object, sets not-empty.
// - Event half flag at half occupancy, all three occupancy flags when full.
// - Transmit into full log discarded, overrun set; host clears it.
// - 32-bit time base counter advances per prescaled tick and wraps.
// - Enable starts counter; disable stops and zeroes it.
// - Stamps attached only when the matching stamp enable is set.
// - Counter wrap raises rollover interrupt when enabled.
// - Capture at start of frame or res bit, or at frame end.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "cmf_consts.vh"
module cmf_fifo_ptr #(
  parameter RX_DEPTH = `CMF_RX_DEPTH,
  parameter Q_DEPTH = `CMF_Q_DEPTH,
  parameter EV_DEPTH = `CMF_EV_DEPTH
) (
  // APB
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // CAN engine events
  input wire rx_msg_done,
  input wire tx_done,
  input wire [28:0] tx_id,
  input wire frame_is_fd,
  input wire sof_sample,
  input wire res_bit_sample,
  input wire rx_eof_point,
  input wire tx_eof_point,
  // Queue identifiers loaded into objects
  input wire [28:0] q_load_id,
  // Stamp, store, queue and interrupt outputs
  output reg rx_store_we,
  output reg [3:0] rx_store_obj,
  output reg ev_store_we,
  output reg [3:0] ev_store_obj,
  output reg [28:0] ev_store_id,
  output reg [31:0] stamp_word,
  output reg stamp_valid,
  output reg queue_tx_valid,
  output reg [2:0] queue_next_index,
  output reg rollover_irq
);
  // Registers
  reg [5:0] ctrl;
  reg [9:0] presc;
  reg [31:0] tbc_load;
  reg tbc_load_pend;
  reg [3:0] rx_rd;
  reg [3:0] fifo_store_index;
  reg [4:0] rx_cnt;
  reg rx_overrun_flag;
  reg [7:0] q_used;
  reg [7:0] q_pend;
  reg [2:0] q_ld;
  reg [28:0] q_id [0:7];
  reg transmit_request;
  reg [3:0] ev_rd;
  reg [3:0] ev_wr;
  reg [4:0] ev_cnt;
  reg event_overrun_flag;
  reg roll_flag;
  reg [31:0] stamp_cap;
  wire [31:0] tbc;
  wire tbc_roll;
  integer i, j, k;

  wire wr_acc = psel & penable & pwrite;
  wire rd_setup = psel & ~penable & ~pwrite; // Launch in setup so data stands in access
  wire cmd_wr = wr_acc & pready & (paddr == `CMF_OFF_CMD);
  wire [31:0] cmd = cmd_wr ? pwdata : 32'h00000000;

  function [3:0] wrap_inc;
    input [3:0] v;
    input [4:0] depth;
    begin
      wrap_inc = ({1'b0, v} == depth - 5'd1) ? 4'h0 : v + 4'h1;
    end
  endfunction

  // Flags from occupancy
  wire rx_not_empty_flag = (rx_cnt != 5'd0);
  wire rx_half_full_flag = (rx_cnt >= RX_DEPTH / 2);
  wire rx_full_flag = (rx_cnt == RX_DEPTH);
  wire [3:0] q_cnt = q_used[0] + q_used[1] + q_used[2] + q_used[3] +
    q_used[4] + q_used[5] + q_used[6] + q_used[7];
  wire queue_empty_flag = (q_cnt == 4'd0);
  wire queue_not_full_flag = (q_cnt != Q_DEPTH);
  wire event_not_empty_flag = (ev_cnt != 5'd0);
  wire event_half_full_flag = (ev_cnt >= EV_DEPTH / 2);
  wire event_full_flag = (ev_cnt == EV_DEPTH);

  // Lowest identifier among pending objects
  reg [2:0] best;
  reg best_ok;
  always @* begin
    best = 3'h0;
    best_ok = 1'b0;
    for (i = 0; i < 8; i = i + 1) begin
      if (q_pend[i] && (!best_ok || q_id[i] < q_id[best])) begin
        best = i[2:0];
        best_ok = 1'b1;
      end
    end
  end

  // First free object for the load address
  reg [2:0] free_obj;
  reg [7:0] used_after;
  always @* begin
    used_after = q_used;
    used_after[q_ld] = 1'b1;
    free_obj = 3'h0;
    for (j = 7; j >= 0; j = j - 1) begin
      if (!used_after[j]) begin
        free_obj = j[2:0];
      end
    end
  end

  wire q_tx_now = tx_done & queue_tx_valid;

  cmf_tbc cmf_tbc_inst (
    .pclk(pclk),
    .presetn(presetn),
    .enable(ctrl[`CMF_CTRL_TBEN]),
    .prescaler(presc),
    .load(tbc_load_pend),
    .load_value(tbc_load),
    .count(tbc),
    .rollover(tbc_roll)
  );

  // Capture point selection
  wire cap_rx = ctrl[`CMF_CTRL_EOF] ? rx_eof_point :
    ((frame_is_fd && ctrl[`CMF_CTRL_RES]) ? res_bit_sample : sof_sample);
  wire cap_tx = ctrl[`CMF_CTRL_EOF] ? tx_eof_point :
    ((frame_is_fd && ctrl[`CMF_CTRL_RES]) ? res_bit_sample : sof_sample);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= 6'h00;
      presc <= 10'h000;
      tbc_load <= 32'h00000000;
      tbc_load_pend <= 1'b0;
      rx_rd <= 4'h0;
      fifo_store_index <= 4'h0;
      rx_cnt <= 5'd0;
      rx_overrun_flag <= 1'b0;
      q_used <= 8'h00;
      q_pend <= 8'h00;
      q_ld <= 3'h0;
      transmit_request <= 1'b0;
      ev_rd <= 4'h0;
      ev_wr <= 4'h0;
      ev_cnt <= 5'd0;
      event_overrun_flag <= 1'b0;
      roll_flag <= 1'b0;
      stamp_cap <= 32'h00000000;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
      rx_store_we <= 1'b0;
      rx_store_obj <= 4'h0;
      ev_store_we <= 1'b0;
      ev_store_obj <= 4'h0;
      ev_store_id <= 29'h0;
      stamp_word <= 32'h00000000;
      stamp_valid <= 1'b0;
      queue_tx_valid <= 1'b0;
      queue_next_index <= 3'h0;
      rollover_irq <= 1'b0;
      for (k = 0; k < 8; k = k + 1) begin
        q_id[k] <= 29'h0;
      end
    end else begin
      // Zero-wait slave: ready during every access phase
      pready <= psel & ~penable;
      pslverr <= 1'b0;
      rx_store_we <= 1'b0;
      ev_store_we <= 1'b0;
      stamp_valid <= 1'b0;
      if (ctrl[`CMF_CTRL_TBEN]) begin
        tbc_load_pend <= 1'b0; // Loaded value must survive until the counter starts
      end
      if (wr_acc && pready) begin
        case (paddr)
          `CMF_OFF_CTRL: ctrl <= pwdata[5:0];
          `CMF_OFF_PRESC: presc <= pwdata[9:0];
          `CMF_OFF_TBC: begin
            tbc_load <= pwdata;
            tbc_load_pend <= ~ctrl[`CMF_CTRL_TBEN];
          end
          `CMF_OFF_CMD: ;
          default: pslverr <= 1'b0;
        endcase
      end
      if (rd_setup) begin
        case (paddr)
          `CMF_OFF_CTRL: prdata <= {26'h0, ctrl};
          `CMF_OFF_PRESC: prdata <= {22'h0, presc};
          `CMF_OFF_TBC: prdata <= tbc;
          `CMF_OFF_RXSTA: prdata <= {15'h0, fifo_store_index, rx_rd, 5'h0,
            rx_overrun_flag, rx_full_flag, rx_half_full_flag, rx_not_empty_flag};
          `CMF_OFF_QSTA: prdata <= {21'h0, queue_next_index, q_ld, transmit_request,
            roll_flag, queue_not_full_flag, queue_empty_flag};
          `CMF_OFF_EVSTA: prdata <= {16'h0, ev_wr, ev_rd, 4'h0, event_overrun_flag,
            event_full_flag, event_half_full_flag, event_not_empty_flag};
          `CMF_OFF_STAMP: prdata <= stamp_cap;
          default: prdata <= 32'h00000000;
        endcase
      end
      // Receive FIFO
      if (cmd[`CMF_CMD_RX_RST]) begin
        rx_rd <= 4'h0;
        fifo_store_index <= 4'h0;
        rx_cnt <= 5'd0;
        rx_overrun_flag <= 1'b0;
      end else begin
        if (rx_msg_done && !rx_full_flag) begin
          fifo_store_index <= wrap_inc(fifo_store_index, RX_DEPTH);
          rx_store_we <= 1'b1;
          rx_store_obj <= fifo_store_index;
        end
        // Set beats host clear in the same cycle
        if (rx_msg_done && rx_full_flag) begin
          rx_overrun_flag <= 1'b1;
        end else if (cmd[`CMF_CMD_RXOV_CLR]) begin
          rx_overrun_flag <= 1'b0;
        end
        if (cmd[`CMF_CMD_RX_INC] && rx_not_empty_flag) begin
          rx_rd <= wrap_inc(rx_rd, RX_DEPTH);
        end
        rx_cnt <= rx_cnt + {4'h0, rx_msg_done & ~rx_full_flag}
          - {4'h0, cmd[`CMF_CMD_RX_INC] & rx_not_empty_flag};
      end
      // Priority queue
      if (cmd[`CMF_CMD_Q_RST]) begin
        q_used <= 8'h00;
        q_pend <= 8'h00;
        q_ld <= 3'h0;
        transmit_request <= 1'b0;
        queue_tx_valid <= 1'b0;
      end else begin
        if (cmd[`CMF_CMD_Q_INC] && queue_not_full_flag) begin
          q_used[q_ld] <= 1'b1;
          q_id[q_ld] <= q_load_id;
          q_ld <= free_obj;
        end
        if (cmd[`CMF_CMD_TRANSMIT_REQUEST]) begin
          transmit_request <= 1'b1;
          q_pend <= q_used;
        end
        if (q_tx_now) begin
          q_used[queue_next_index] <= 1'b0;
          q_pend[queue_next_index] <= 1'b0;
          if ((q_pend & ~(8'h01 << queue_next_index)) == 8'h00) begin
            transmit_request <= 1'b0;
          end
        end
        // Recomputed, never incremented
        queue_next_index <= best;
        queue_tx_valid <= best_ok & transmit_request & ~q_tx_now;
      end
      // Event log
      if (cmd[`CMF_CMD_EV_RST]) begin
        ev_rd <= 4'h0;
        ev_wr <= 4'h0;
        ev_cnt <= 5'd0;
        event_overrun_flag <= 1'b0;
      end else begin
        if (tx_done && !event_full_flag) begin
          ev_store_we <= 1'b1;
          ev_store_obj <= ev_wr;
          ev_store_id <= tx_id;
          ev_wr <= wrap_inc(ev_wr, EV_DEPTH);
        end
        if (tx_done && event_full_flag) begin
          event_overrun_flag <= 1'b1;
        end else if (cmd[`CMF_CMD_EVOV_CLR]) begin
          event_overrun_flag <= 1'b0;
        end
        if (cmd[`CMF_CMD_EV_INC] && event_not_empty_flag) begin
          ev_rd <= wrap_inc(ev_rd, EV_DEPTH);
        end
        ev_cnt <= ev_cnt + {4'h0, tx_done & ~event_full_flag}
          - {4'h0, cmd[`CMF_CMD_EV_INC] & event_not_empty_flag};
      end
      // Timestamp capture and delivery
      if (cap_rx || cap_tx) begin
        stamp_cap <= tbc;
      end
      if ((rx_msg_done && !rx_full_flag && ctrl[`CMF_CTRL_RXTS]) ||
          (tx_done && !event_full_flag && ctrl[`CMF_CTRL_EVTS])) begin
        stamp_word <= stamp_cap;
        stamp_valid <= 1'b1;
      end
      // Rollover sticky, set wins over clear
      if (tbc_roll) begin
        roll_flag <= 1'b1;
      end else if (cmd[`CMF_CMD_ROLL_CLR]) begin
        roll_flag <= 1'b0;
      end
      rollover_irq <= (roll_flag | tbc_roll) & ctrl[`CMF_CTRL_ROLLIE] &
        ~(cmd[`CMF_CMD_ROLL_CLR] & ~tbc_roll);
    end
  end
endmodule // cmf_fifo_ptr
`default_nettype wire

// ### src/cmf_tbc.v
// Time base counter with prescaler.
// Assumes prescaler and enable are synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module cmf_tbc (
  // Clock and reset
  input wire pclk,
  input wire presetn,
  // Control
  input wire enable,
  input wire [9:0] prescaler,
  input wire load,
  input wire [31:0] load_value,
  // Result
  output reg [31:0] count,
  output reg rollover
);
  reg [9:0] div;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div <= 10'h000;
      count <= 32'h00000000;
      rollover <= 1'b0;
    end else begin
      rollover <= 1'b0;
      if (!enable) begin
        div <= 10'h000;
        // Load only while stopped; disable otherwise zeroes value
        count <= load ? load_value : 32'h00000000;
      end else if (div >= prescaler) begin
        div <= 10'h000;
        count <= count + 32'h00000001;
        rollover <= (count == 32'hffffffff);
      end else begin
        div <= div + 10'h001;
      end
    end
  end
endmodule // cmf_tbc
`default_nettype wire
